/* pkg/flash_front_pkg.sv */
// Opcodes, status layout, timing and pin carriers of the serial flash command front end.
package flash_front_pkg;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_VOLATILE_ENABLE = 8'h50;
	localparam logic [7:0] OP_STATUS_WRITE_LO = 8'h01;
	localparam logic [7:0] OP_STATUS_WRITE_MID = 8'h31;
	localparam logic [7:0] OP_STATUS_WRITE_HI = 8'h11;
	localparam logic [7:0] OP_STATUS_READ_LO = 8'h05;
	localparam logic [7:0] OP_STATUS_READ_MID = 8'h35;
	localparam logic [7:0] OP_STATUS_READ_HI = 8'h15;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST_READ = 8'h0b;
	localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3b;
	localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6b;
	localparam logic [7:0] OP_DUAL_IO_READ = 8'hbb;
	localparam logic [7:0] OP_QUAD_IO_READ = 8'heb;
	localparam logic [7:0] OP_BURST_SETUP = 8'h77;
	localparam logic [7:0] OP_REPEAT_RESET = 8'hff;
	// Last clock index of each phase, per lane width.
	localparam logic [5:0] CMD_LAST = 6'h07;
	localparam logic [5:0] ADDR_LAST_SINGLE = 6'h17;
	localparam logic [5:0] ADDR_LAST_DUAL = 6'h0b;
	localparam logic [5:0] ADDR_LAST_QUAD = 6'h05;
	localparam logic [5:0] MODE_LAST_DUAL = 6'h03;
	localparam logic [5:0] MODE_LAST_QUAD = 6'h01;
	localparam logic [5:0] DUMMY_LAST_SINGLE = 6'h07;
	localparam logic [5:0] DUMMY_LAST_QUAD = 6'h03;
	localparam logic [5:0] BURST_LAST = 6'h1f;
	localparam logic [5:0] DATA_BYTE_LAST = 6'h07;
	// Lane width codes.
	localparam logic [1:0] LANE_SINGLE = 2'h0;
	localparam logic [1:0] LANE_DUAL = 2'h1;
	localparam logic [1:0] LANE_QUAD = 2'h2;
	// Status word layout.
	localparam int BIT_CYCLE_ACTIVE = 0;
	localparam int BIT_WRITE_PERMIT = 1;
	localparam int BIT_LOCK_LOW = 7;
	localparam int BIT_LOCK_HIGH = 8;
	localparam int BIT_QUAD_PERMIT = 9;
	localparam logic [23:0] STATUS_WRITE_MASK = 24'h607ffc;
	localparam logic [23:0] STATUS_RESET = 24'h000000;
	localparam logic [1:0] REPEAT_ARM = 2'h2;
	localparam int WRAP_OFF_POS = 4;
	localparam int WRAP_SIZE_POS = 5;
	localparam logic WRAP_OFF_RESET = 1'b1;
	localparam logic [1:0] WRAP_SIZE_RESET = 2'h0;
	localparam logic [5:0] WRAP_BASE_BYTES = 6'h08;
	localparam int CORE_CLK_MHZ = 50;
	localparam int STATUS_WRITE_TIME_US_DEFAULT = 10;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic wp_n;
		logic [3:0] io;
	} pin_in_t;

	typedef struct packed {
		logic [3:0] io_out;
		logic [3:0] io_oe;
	} pin_out_t;

	localparam pin_in_t PIN_IDLE = '{cs_n: 1'b1, sclk: 1'b0, wp_n: 1'b1, io: 4'h0};

	typedef enum logic [3:0] {
		ST_IDLE, ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_STAT_OUT,
		ST_WRITE, ST_WR_HELD, ST_BURST, ST_END, ST_IGNORE
	} link_state_t;
endpackage

/* rtl/flash_front.sv */
// Serial flash command front end: status write, volatile enable, burst setup and reads.
`timescale 1ns/1ps

module flash_front import flash_front_pkg::*; #(
	parameter int STATUS_WRITE_TIME_US = flash_front_pkg::STATUS_WRITE_TIME_US_DEFAULT
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Serial pins
	input flash_front_pkg::pin_in_t pins_in,
	output flash_front_pkg::pin_out_t pins_out,
	// Array read port
	output logic [23:0] rd_addr,
	input wire logic [7:0] rd_data,
	input wire logic array_busy,
	// Status view
	output logic [23:0] status_word,
	output logic write_permit_latch,
	output logic cycle_active_flag,
	output logic quad_io_permit,
	output logic wrap_off_flag,
	output logic [1:0] wrap_size_code
);
	import flash_front_pkg::*;

	localparam logic [31:0] WRITE_CYCLES = 32'(STATUS_WRITE_TIME_US * CORE_CLK_MHZ);

	if (STATUS_WRITE_TIME_US < 1) begin : g_bad_time
		$error("status write time must be at least one microsecond");
	end

	// Pin synchroniser: a change is taken once the second and third stages agree.
	pin_in_t s1_q, s2_q, s3_q, filt_q, filt_d;
	assign filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s1_q <= PIN_IDLE;
			s2_q <= PIN_IDLE;
			s3_q <= PIN_IDLE;
			filt_q <= PIN_IDLE;
		end else begin
			s1_q <= pins_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= filt_d;
		end
	end

	logic sclk_rise, sclk_fall, cs_rise;
	logic [3:0] io;
	assign sclk_rise = filt_d.sclk & ~filt_q.sclk;
	assign sclk_fall = ~filt_d.sclk & filt_q.sclk;
	assign cs_rise = filt_d.cs_n & ~filt_q.cs_n;
	assign io = filt_d.io;

	// Link state.
	link_state_t state_q, state_d;
	logic [5:0] cnt_q, cnt_d;
	logic [23:0] sh_q, sh_d;
	logic [7:0] op_q, op_d;
	logic [1:0] lanes_q, lanes_d;
	logic [23:0] rd_addr_q, rd_addr_d;
	logic [7:0] osh_q, osh_d;
	logic [2:0] opos_q, opos_d;
	pin_out_t out_q, out_d;
	logic pend_q, pend_d;
	logic [7:0] wr_byte_q, wr_byte_d;
	logic cont_dual_q, cont_dual_d, cont_quad_q, cont_quad_d;
	logic wrap_off_q, wrap_off_d;
	logic [1:0] wrap_size_q, wrap_size_d;

	// Status state.
	logic [23:0] status_q, status_d;
	logic wel_q, wel_d, vol_q, vol_d, active_q, active_d;
	logic [31:0] timer_q, timer_d;

	logic busy, hw_prot;
	logic [23:0] shifted, view, next_addr, wrap_mask;
	logic [7:0] opcode, stat_byte, src_byte, ob;
	logic [5:0] addr_last, mode_last;
	assign busy = active_q | array_busy;
	assign hw_prot = status_q[BIT_LOCK_HIGH] | (status_q[BIT_LOCK_LOW] & ~filt_q.wp_n);
	assign view = {status_q[23:2], wel_q, active_q};
	assign opcode = {sh_q[6:0], io[0]};
	assign addr_last = (lanes_q == LANE_QUAD) ? ADDR_LAST_QUAD :
		(lanes_q == LANE_DUAL) ? ADDR_LAST_DUAL : ADDR_LAST_SINGLE;
	assign mode_last = (lanes_q == LANE_QUAD) ? MODE_LAST_QUAD : MODE_LAST_DUAL;
	assign stat_byte = (op_q == OP_STATUS_READ_HI) ? view[23:16] :
		(op_q == OP_STATUS_READ_MID) ? view[15:8] : view[7:0];
	assign src_byte = (state_q == ST_STAT_OUT) ? stat_byte : rd_data;
	// Wrapping keeps the high address bits and rolls only inside the section.
	assign wrap_mask = {18'h0, 6'((WRAP_BASE_BYTES << wrap_size_q) - 6'h01)};
	always_comb begin
		next_addr = rd_addr_q + 24'h000001;
		if (op_q == OP_QUAD_IO_READ && !wrap_off_q) begin
			next_addr = (rd_addr_q & ~wrap_mask) | (next_addr & wrap_mask);
		end
	end

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		op_d = op_q;
		lanes_d = lanes_q;
		rd_addr_d = rd_addr_q;
		osh_d = osh_q;
		opos_d = opos_q;
		out_d = out_q;
		pend_d = pend_q;
		wr_byte_d = wr_byte_q;
		cont_dual_d = cont_dual_q;
		cont_quad_d = cont_quad_q;
		wrap_off_d = wrap_off_q;
		wrap_size_d = wrap_size_q;
		ob = (opos_q == 3'h0) ? src_byte : osh_q;
		if (lanes_q == LANE_QUAD) begin
			shifted = {sh_q[19:0], io};
		end else if (lanes_q == LANE_DUAL) begin
			shifted = {sh_q[21:0], io[1:0]};
		end else begin
			shifted = {sh_q[22:0], io[0]};
		end
		if (filt_d.cs_n) begin
			state_d = ST_IDLE;
			out_d.io_oe = 4'h0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					cnt_d = 6'h00;
					sh_d = 24'h000000;
					pend_d = 1'b0;
					opos_d = 3'h0;
					state_d = ST_CMD;
					lanes_d = LANE_SINGLE;
					if (cont_quad_q && !busy) begin
						op_d = OP_QUAD_IO_READ;
						lanes_d = LANE_QUAD;
						state_d = ST_ADDR;
					end else if (cont_dual_q && !busy) begin
						op_d = OP_DUAL_IO_READ;
						lanes_d = LANE_DUAL;
						state_d = ST_ADDR;
					end
				end
				ST_CMD: begin
					if (sclk_rise) begin
						sh_d = shifted;
						cnt_d = cnt_q + 6'h01;
						if (cnt_q == CMD_LAST) begin
							cnt_d = 6'h00;
							op_d = opcode;
							case (opcode)
								OP_WRITE_ENABLE, OP_WRITE_DISABLE, OP_VOLATILE_ENABLE: state_d = ST_END;
								OP_STATUS_WRITE_LO, OP_STATUS_WRITE_MID, OP_STATUS_WRITE_HI: state_d = ST_WRITE;
								OP_STATUS_READ_LO, OP_STATUS_READ_MID, OP_STATUS_READ_HI: begin
									state_d = ST_STAT_OUT;
								end
								OP_BURST_SETUP: state_d = ST_BURST;
								OP_READ, OP_FAST_READ, OP_DUAL_OUT_READ, OP_QUAD_OUT_READ: begin
									state_d = busy ? ST_IGNORE : ST_ADDR;
								end
								OP_DUAL_IO_READ: begin
									state_d = busy ? ST_IGNORE : ST_ADDR;
									lanes_d = LANE_DUAL;
								end
								OP_QUAD_IO_READ: begin
									state_d = (busy || !status_q[BIT_QUAD_PERMIT]) ? ST_IGNORE : ST_ADDR;
									lanes_d = LANE_QUAD;
								end
								OP_REPEAT_RESET: begin
									cont_dual_d = 1'b0;
									cont_quad_d = 1'b0;
									state_d = ST_IGNORE;
								end
								default: state_d = ST_IGNORE;
							endcase
						end
					end
				end
				ST_ADDR: begin
					if (sclk_rise) begin
						sh_d = shifted;
						cnt_d = cnt_q + 6'h01;
						if (cnt_q == addr_last) begin
							cnt_d = 6'h00;
							rd_addr_d = shifted;
							case (op_q)
								OP_READ: state_d = ST_DATA;
								OP_DUAL_IO_READ, OP_QUAD_IO_READ: state_d = ST_MODE;
								OP_DUAL_OUT_READ: begin
									state_d = ST_DUMMY;
									lanes_d = LANE_DUAL;
								end
								OP_QUAD_OUT_READ: begin
									state_d = ST_DUMMY;
									lanes_d = LANE_QUAD;
								end
								default: state_d = ST_DUMMY;
							endcase
						end
					end
				end
				ST_MODE: begin
					if (sclk_rise) begin
						sh_d = shifted;
						cnt_d = cnt_q + 6'h01;
						if (cnt_q == mode_last) begin
							cnt_d = 6'h00;
							if (op_q == OP_QUAD_IO_READ) begin
								cont_quad_d = (shifted[5:4] == REPEAT_ARM);
								state_d = ST_DUMMY;
							end else begin
								cont_dual_d = (shifted[5:4] == REPEAT_ARM);
								state_d = ST_DATA;
							end
						end
					end
				end
				ST_DUMMY: begin
					if (sclk_rise) begin
						cnt_d = cnt_q + 6'h01;
						if (cnt_q == ((op_q == OP_QUAD_IO_READ) ? DUMMY_LAST_QUAD : DUMMY_LAST_SINGLE)) begin
							cnt_d = 6'h00;
							state_d = ST_DATA;
						end
					end
				end
				ST_DATA, ST_STAT_OUT: begin
					if (sclk_fall) begin
						unique case (lanes_q)
							LANE_QUAD: begin
								out_d = '{io_out: ob[7:4], io_oe: 4'hf};
								osh_d = {ob[3:0], 4'h0};
								opos_d = (opos_q == 3'h0) ? 3'h1 : opos_q - 3'h1;
							end
							LANE_DUAL: begin
								out_d = '{io_out: {2'h0, ob[7:6]}, io_oe: 4'h3};
								osh_d = {ob[5:0], 2'h0};
								opos_d = (opos_q == 3'h0) ? 3'h3 : opos_q - 3'h1;
							end
							default: begin
								out_d = '{io_out: {2'h0, ob[7], 1'b0}, io_oe: 4'h2};
								osh_d = {ob[6:0], 1'b0};
								opos_d = (opos_q == 3'h0) ? 3'h7 : opos_q - 3'h1;
							end
						endcase
						if (opos_q == 3'h0 && state_q == ST_DATA) begin
							rd_addr_d = next_addr;
						end
					end
				end
				ST_WRITE: begin
					if (sclk_rise) begin
						sh_d = shifted;
						cnt_d = cnt_q + 6'h01;
						if (cnt_q == DATA_BYTE_LAST) begin
							wr_byte_d = shifted[7:0];
							pend_d = 1'b1;
							state_d = ST_WR_HELD;
						end
					end
				end
				ST_WR_HELD: begin
					if (sclk_rise) begin
						pend_d = 1'b0;
						state_d = ST_IGNORE;
					end
				end
				ST_BURST: begin
					if (sclk_rise) begin
						sh_d = shifted;
						cnt_d = cnt_q + 6'h01;
						if (cnt_q == BURST_LAST) begin
							wrap_off_d = shifted[WRAP_OFF_POS];
							wrap_size_d = shifted[WRAP_SIZE_POS +: 2];
							state_d = ST_END;
						end
					end
				end
				ST_END, ST_IGNORE: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			cnt_q <= 6'h00;
			sh_q <= 24'h000000;
			op_q <= 8'h00;
			lanes_q <= LANE_SINGLE;
			rd_addr_q <= 24'h000000;
			osh_q <= 8'h00;
			opos_q <= 3'h0;
			out_q <= '{io_out: 4'h0, io_oe: 4'h0};
			pend_q <= 1'b0;
			wr_byte_q <= 8'h00;
			cont_dual_q <= 1'b0;
			cont_quad_q <= 1'b0;
			wrap_off_q <= WRAP_OFF_RESET;
			wrap_size_q <= WRAP_SIZE_RESET;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			op_q <= op_d;
			lanes_q <= lanes_d;
			rd_addr_q <= rd_addr_d;
			osh_q <= osh_d;
			opos_q <= opos_d;
			out_q <= out_d;
			pend_q <= pend_d;
			wr_byte_q <= wr_byte_d;
			cont_dual_q <= cont_dual_d;
			cont_quad_q <= cont_quad_d;
			wrap_off_q <= wrap_off_d;
			wrap_size_q <= wrap_size_d;
		end
	end

	// Status register, write permit latch and the self-timed write cycle.
	logic [23:0] sel_mask, merged;
	logic wr_ok;
	assign sel_mask = ((op_q == OP_STATUS_WRITE_HI) ? 24'hff0000 :
		(op_q == OP_STATUS_WRITE_MID) ? 24'h00ff00 : 24'h0000ff) & STATUS_WRITE_MASK;
	assign merged = (status_q & ~sel_mask) | ({3{wr_byte_q}} & sel_mask);
	assign wr_ok = cs_rise && state_q == ST_WR_HELD && pend_q && (wel_q || vol_q) && !busy && !hw_prot;

	always_comb begin
		status_d = status_q;
		wel_d = wel_q;
		vol_d = vol_q;
		active_d = active_q;
		timer_d = timer_q;
		if (active_q) begin
			timer_d = timer_q - 32'h00000001;
			if (timer_q == 32'h00000001) begin
				active_d = 1'b0;
				wel_d = 1'b0;
			end
		end
		if (cs_rise) begin
			vol_d = (state_q == ST_END && op_q == OP_VOLATILE_ENABLE);
			if (state_q == ST_END && !busy && op_q == OP_WRITE_ENABLE) begin
				wel_d = 1'b1;
			end
			if (state_q == ST_END && !busy && op_q == OP_WRITE_DISABLE) begin
				wel_d = 1'b0;
			end
			if (wr_ok) begin
				status_d = merged;
				// A volatile update takes effect at once and leaves the latch alone.
				if (!vol_q) begin
					active_d = 1'b1;
					timer_d = WRITE_CYCLES;
				end
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			status_q <= STATUS_RESET;
			wel_q <= 1'b0;
			vol_q <= 1'b0;
			active_q <= 1'b0;
			timer_q <= 32'h00000000;
		end else begin
			status_q <= status_d;
			wel_q <= wel_d;
			vol_q <= vol_d;
			active_q <= active_d;
			timer_q <= timer_d;
		end
	end

	assign pins_out = out_q;
	assign rd_addr = rd_addr_q;
	assign status_word = view;
	assign write_permit_latch = wel_q;
	assign cycle_active_flag = active_q;
	assign quad_io_permit = status_q[BIT_QUAD_PERMIT];
	assign wrap_off_flag = wrap_off_q;
	assign wrap_size_code = wrap_size_q;

	sequence stat_write_accept;
		state_q == ST_WR_HELD && pend_q && cs_rise && wel_q && !vol_q && !busy && !hw_prot;
	endsequence

	sequence cycle_running;
		active_q [*8];
	endsequence

	chk_write_cycle_start: assert property (@(posedge core_clk) disable iff (rst)
		stat_write_accept |=> active_q && timer_q == WRITE_CYCLES ##0 cycle_running)
		else $error("status write cycle did not start and run");
	chk_permit_needed: assert property (@(posedge core_clk) disable iff (rst)
		$rose(active_q) |-> $past(wel_q) && !$past(vol_q))
		else $error("write cycle started without write permit");
	chk_permit_clear_end: assert property (@(posedge core_clk) disable iff (rst)
		active_q && timer_q == 32'h00000001 |=> !active_q && !wel_q)
		else $error("cycle end did not clear write permit");
	chk_fixed_bits_kept: assert property (@(posedge core_clk) disable iff (rst)
		((status_q ^ $past(status_q)) & ~STATUS_WRITE_MASK) == 24'h000000)
		else $error("fixed status bit changed");
	chk_hw_protect_blocks: assert property (@(posedge core_clk) disable iff (rst)
		cs_rise && hw_prot |=> $stable(status_q) && $stable(active_q))
		else $error("status changed under hardware protection");
	chk_volatile_no_permit: assert property (@(posedge core_clk) disable iff (rst)
		cs_rise && state_q == ST_END && op_q == OP_VOLATILE_ENABLE && !wel_q |=> !wel_q)
		else $error("volatile enable set the write permit latch");
	chk_late_edge_discard: assert property (@(posedge core_clk) disable iff (rst)
		state_q == ST_WR_HELD && sclk_rise && !filt_d.cs_n |=> !pend_q ##1 !$rose(active_q))
		else $error("overlong status write was kept");
	chk_busy_read_reject: assert property (@(posedge core_clk) disable iff (rst)
		state_q == ST_CMD && sclk_rise && cnt_q == CMD_LAST && opcode == OP_READ && busy
		&& !filt_d.cs_n |=> state_q == ST_IGNORE
		&& (!$past(active_q) || timer_q == $past(timer_q) - 32'h00000001))
		else $error("read accepted during a running cycle");
	chk_quad_permit: assert property (@(posedge core_clk) disable iff (rst)
		state_q == ST_ADDR && op_q == OP_QUAD_IO_READ |-> status_q[BIT_QUAD_PERMIT] || cont_quad_q)
		else $error("quad IO read without quad permit");
	chk_oe_data_only: assert property (@(posedge core_clk) disable iff (rst)
		out_q.io_oe != 4'h0 |-> $past(state_q == ST_DATA || state_q == ST_STAT_OUT))
		else $error("IO lines driven outside the data phase");
	chk_wrap_window: assert property (@(posedge core_clk) disable iff (rst)
		state_q == ST_DATA && op_q == OP_QUAD_IO_READ && !wrap_off_q && rd_addr_q != rd_addr_d
		|=> (rd_addr_q & ~wrap_mask) == ($past(rd_addr_q) & ~wrap_mask))
		else $error("wrapped read left its section");
endmodule // flash_front

/* verification/flash_host_model.sv */
// Host controller model that drives select, serial clock and IO lines of the flash front end.
`timescale 1ns/1ps
module flash_host_model import flash_front_pkg::*; (
	// Clock and guard pin level
	input wire logic core_clk,
	input wire logic wp_n,
	// Device pins
	input flash_front_pkg::pin_out_t pins_out,
	output flash_front_pkg::pin_in_t pins_in
);
	import flash_front_pkg::*;
	logic cs_n = 1'b1;
	logic sclk = 1'b0;
	logic flip = 1'b0;
	logic [3:0] drv = 4'h0;
	logic [3:0] den = 4'h0;
	logic [3:0] last_oe = 4'h0;
	logic [7:0] got_byte = 8'h00;
	int clash = 0;
	event byte_ev;
	// Undriven lines toggle each cycle, so a stale level can never pass for data.
	always @(posedge core_clk) begin
		flip <= ~flip;
		if (|(pins_out.io_oe & den)) begin
			clash <= clash + 1;
		end
	end
	always_comb begin
		pins_in.cs_n = cs_n;
		pins_in.sclk = sclk;
		pins_in.wp_n = wp_n;
		for (int i = 0; i < 4; i++) begin
			pins_in.io[i] = pins_out.io_oe[i] ? pins_out.io_out[i] : den[i] ? drv[i] : flip ^ i[0];
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// One serial clock: data changes just after the fall, output is sampled before the next fall.
	task automatic cyc(input logic [3:0] d, input logic [3:0] en, output logic [3:0] seen);
		tick(1);
		drv = d;
		den = en;
		tick(3);
		sclk = 1'b1;
		tick(4);
		seen = pins_out.io_out;
		last_oe = pins_out.io_oe;
		sclk = 1'b0;
	endtask
	task automatic sel();
		tick(1);
		cs_n = 1'b0;
		tick(4);
	endtask
	task automatic desel();
		tick(4);
		cs_n = 1'b1;
		den = 4'h0;
		tick(8);
	endtask
	task automatic send(input logic [1:0] lane, input logic [31:0] val, input int n);
		int w;
		logic [3:0] s;
		w = 1 << lane;
		for (int i = n - w; i >= 0; i -= w) begin
			cyc(4'((val >> i) & ((1 << w) - 1)), 4'((1 << w) - 1), s);
		end
	endtask
	// A byte is published only if the device drove some line while it was read.
	task automatic recv(input logic [1:0] lane, input int n);
		int w;
		logic [3:0] s;
		logic [7:0] b;
		logic vis;
		w = 1 << lane;
		b = 8'h00;
		for (int k = 0; k < n; k++) begin
			vis = 1'b0;
			for (int i = 0; i < 8; i += w) begin
				cyc(4'h0, 4'h0, s);
				b = (w == 1) ? {b[6:0], s[1]} : (w == 2) ? {b[5:0], s[1:0]} : {b[3:0], s};
				vis = vis | (|last_oe);
			end
			got_byte = b;
			if (vis) begin
				->byte_ev;
			end
		end
	endtask
endmodule // flash_host_model

/* verification/tb_flash_front.sv */
// Self-checking bench for the serial flash command front end.
`timescale 1ns/1ps
module tb_flash_front;
	import flash_front_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic wp_n = 1'b1;
	logic array_busy = 1'b0;
	logic [7:0] rd_data;
	logic [23:0] rd_addr;
	logic [23:0] status_word;
	logic write_permit_latch;
	logic cycle_active_flag;
	logic quad_io_permit;
	logic wrap_off_flag;
	logic [1:0] wrap_size_code;
	pin_in_t pins_in;
	pin_out_t pins_out;
	logic [7:0] exp_q[$];
	logic [23:0] exp_sw = 24'h000000;
	logic [31:0] seed = 32'h0000d18c;
	int wrap_len = 0;
	int bad_count = 0;
	int check_count = 0;
	initial begin
		forever #10 core_clk = ~core_clk;
	end
	flash_front #(.STATUS_WRITE_TIME_US(10)) dut (.core_clk(core_clk), .rst(rst),
		.pins_in(pins_in), .pins_out(pins_out), .rd_addr(rd_addr), .rd_data(rd_data),
		.array_busy(array_busy), .status_word(status_word),
		.write_permit_latch(write_permit_latch), .cycle_active_flag(cycle_active_flag),
		.quad_io_permit(quad_io_permit), .wrap_off_flag(wrap_off_flag),
		.wrap_size_code(wrap_size_code));
	flash_host_model host (.core_clk(core_clk), .wp_n(wp_n), .pins_out(pins_out),
		.pins_in(pins_in));
	function automatic logic [7:0] mem_byte(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3c;
	endfunction
	assign rd_data = mem_byte(rd_addr);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d, mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always @(host.byte_ev) begin
		check({16'h0, host.got_byte}, exp_q.size() ? {16'h0, exp_q.pop_front()} : 24'hffffff);
	end
	task automatic cmd(input logic [7:0] op);
		host.sel();
		host.send(LANE_SINGLE, {24'h0, op}, 8);
		host.desel();
	endtask
	task automatic stat_wr(input logic we, input logic [7:0] op, input logic [7:0] v);
		if (we) begin
			cmd(OP_WRITE_ENABLE);
		end
		host.sel();
		host.send(LANE_SINGLE, {16'h0, op, v}, 16);
		host.desel();
	endtask
	task automatic wait_done();
		for (int i = 0; i < 1000 && cycle_active_flag !== 1'b0; i++) begin
			host.tick(1);
		end
	endtask
	task automatic stat_rd(input logic [7:0] op, input logic [7:0] e);
		exp_q.push_back(e);
		host.sel();
		host.send(LANE_SINGLE, {24'h0, op}, 8);
		host.recv(LANE_SINGLE, 1);
		host.desel();
	endtask
	task automatic rd(input logic [7:0] op, input logic [23:0] a, input int n,
		input logic [7:0] m, input logic cont, input logic ok);
		logic [1:0] ln;
		logic [23:0] ea;
		ln = (op == OP_DUAL_OUT_READ || op == OP_DUAL_IO_READ) ? LANE_DUAL :
			(op == OP_QUAD_OUT_READ || op == OP_QUAD_IO_READ) ? LANE_QUAD : LANE_SINGLE;
		host.sel();
		if (!cont) begin
			host.send(LANE_SINGLE, {24'h0, op}, 8);
		end
		if (op == OP_DUAL_IO_READ || op == OP_QUAD_IO_READ) begin
			host.send(ln, {a, m}, 32);
		end else begin
			host.send(LANE_SINGLE, {8'h0, a}, 24);
		end
		if (op == OP_QUAD_IO_READ) begin
			host.recv(LANE_QUAD, 2);
		end else if (op != OP_READ && op != OP_DUAL_IO_READ) begin
			host.send(LANE_SINGLE, 32'h0, 8);
		end
		for (int i = 0; i < n; i++) begin
			ea = a + 24'(i);
			if (wrap_len > 0 && op == OP_QUAD_IO_READ) begin
				ea = (a & ~24'(wrap_len - 1)) | (ea & 24'(wrap_len - 1));
			end
			if (ok) begin
				exp_q.push_back(mem_byte(ea));
			end
		end
		host.recv(ln, n);
		host.desel();
		check({20'h0, host.last_oe}, ok ? 24'(((1 << (1 << ln)) - 1) << (ln == 0)) : 24'h0);
	endtask
	initial begin
		logic [7:0] b;
		logic [23:0] a;
		logic [7:0] ops[4];
		ops = '{OP_READ, OP_FAST_READ, OP_DUAL_OUT_READ, OP_QUAD_OUT_READ};
		repeat (16) @(posedge core_clk);
		#1;
		rst = 1'b0;
		host.tick(4);
		check(status_word, STATUS_RESET);
		check({20'h0, write_permit_latch, wrap_off_flag, wrap_size_code}, 24'h000004);
		stat_wr(1'b0, OP_STATUS_WRITE_LO, 8'hfc);
		check(status_word, 24'h000000);
		cmd(OP_VOLATILE_ENABLE);
		check(24'(write_permit_latch), 24'h000000);
		cmd(OP_WRITE_ENABLE);
		check(24'(write_permit_latch), 24'h000001);
		cmd(OP_WRITE_DISABLE);
		check(24'(write_permit_latch), 24'h000000);
		cmd(OP_WRITE_ENABLE);
		check(24'(write_permit_latch), 24'h000001);
		host.sel();
		host.send(LANE_SINGLE, {15'h0, OP_STATUS_WRITE_MID, 9'h1ff}, 17);
		host.desel();
		check(status_word, 24'h000002);
		rd(OP_QUAD_IO_READ, 24'(rnd()), 1, 8'h00, 1'b0, 1'b0);
		b = (8'(rnd()) | 8'h02) & 8'hfe;
		stat_wr(1'b1, OP_STATUS_WRITE_MID, b);
		exp_sw[15:8] = b & 8'h7f;
		check(24'(cycle_active_flag), 24'h000001);
		check(24'(quad_io_permit), 24'h000001);
		stat_rd(OP_STATUS_READ_LO, 8'h03);
		rd(OP_READ, 24'(rnd()), 2, 8'h00, 1'b0, 1'b0);
		wait_done();
		check(status_word, exp_sw);
		stat_wr(1'b1, OP_STATUS_WRITE_HI, 8'hff);
		wait_done();
		stat_wr(1'b1, OP_STATUS_WRITE_LO, 8'hff);
		wait_done();
		exp_sw[23:16] = 8'h60;
		exp_sw[7:2] = 6'h3f;
		check(status_word, exp_sw);
		stat_rd(OP_STATUS_READ_HI, exp_sw[23:16]);
		stat_rd(OP_STATUS_READ_MID, exp_sw[15:8]);
		wp_n = 1'b0;
		stat_wr(1'b1, OP_STATUS_WRITE_LO, 8'h00);
		wait_done();
		check(status_word, exp_sw | 24'h000002);
		wp_n = 1'b1;
		stat_wr(1'b0, OP_STATUS_WRITE_LO, 8'h00);
		wait_done();
		exp_sw[7:0] = 8'h00;
		check(status_word, exp_sw);
		cmd(OP_VOLATILE_ENABLE);
		stat_wr(1'b0, OP_STATUS_WRITE_HI, 8'h00);
		exp_sw[23:16] = 8'h00;
		check(status_word, exp_sw);
		array_busy = 1'b1;
		rd(OP_FAST_READ, 24'(rnd()), 1, 8'h00, 1'b0, 1'b0);
		array_busy = 1'b0;
		for (int k = 0; k < 4; k++) begin
			rd(ops[k], 24'(rnd()), 3, 8'h00, 1'b0, 1'b1);
		end
		a = 24'(rnd());
		rd(OP_DUAL_IO_READ, a, 2, 8'h20, 1'b0, 1'b1);
		rd(OP_DUAL_IO_READ, a + 24'h000011, 2, 8'h00, 1'b1, 1'b1);
		rd(OP_READ, a, 2, 8'h00, 1'b0, 1'b1);
		rd(OP_QUAD_IO_READ, a, 2, 8'h20, 1'b0, 1'b1);
		rd(OP_QUAD_IO_READ, a + 24'h000023, 2, 8'h00, 1'b1, 1'b1);
		rd(OP_READ, a, 2, 8'h00, 1'b0, 1'b1);
		for (int s = 0; s < 5; s++) begin
			host.sel();
			host.send(LANE_SINGLE, {24'h0, OP_BURST_SETUP}, 8);
			host.send(LANE_SINGLE, {24'h0, (s == 4) ? 8'h10 : {1'b0, 2'(s), 5'h00}}, 32);
			host.desel();
			check(24'({wrap_off_flag, wrap_size_code}), (s == 4) ? 24'h000004 : 24'(s));
			wrap_len = (s == 4) ? 0 : 8 << s;
			rd(OP_QUAD_IO_READ, 24'(rnd()), 10, 8'h00, 1'b0, 1'b1);
		end
		check(24'(host.clash), 24'h000000);
		check(24'(exp_q.size()), 24'h000000);
		close_out();
	end
	initial begin
		#1000000;
		bad_count++;
		close_out();
	end
endmodule // tb_flash_front
